// ---- verilog/bcs_pkg.sv ----
// Shared constants of the bus clock stop control block.
// Assumes one system clock; counts are in system clock cycles, except BCS_RESTART_PERIODS, which is in bus clock periods.
package bcs_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  // System clock period in picoseconds
  localparam int BCS_SYS_PERIOD_PS = 25000;
  // System cycles per half bus clock period
  localparam int BCS_HALF_PERIOD_CYC = 1;
  // Bus clock periods allowed for a restart
  localparam int BCS_RESTART_PERIODS = 2;

  // ************************************************************
  // Output counts and reset values
  // ************************************************************
  localparam int BCS_NUM_STOP = 7;
  localparam int BCS_NUM_FREE = 3;
  localparam logic BCS_PHASE_RST = 1'h0;
  localparam logic BCS_READBACK_RST = 1'h0;

  // ************************************************************
  // Gating state, one-hot
  // ************************************************************
  typedef enum logic [1:0] {
    BCS_ST_RUNNING = 2'h1,
    BCS_ST_STOPPED = 2'h2
  } bcs_state_t;

endpackage : bcs_pkg

// ---- verilog/bcs_divider.sv ----
// Bus clock phase generator for the stop control block.
// Assumes the system clock is at least twice the bus clock rate.
`timescale 1ns/1ps
module bcs_divider import bcs_pkg::*; #(
  parameter int HALF_CYC = BCS_HALF_PERIOD_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Phase outputs
  output logic phase_next_out,
  output logic rise_out
);

  localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(HALF_CYC - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;

  if (HALF_CYC < 1) begin : g_bad_half
    $error("HALF_CYC must be at least one");
  end

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic phase_reg;
  logic phase_next;

  // ************************************************************
  // Half period counter and phase toggle
  // ************************************************************
  // Next count and phase; phase flips at the end of each half period
  always_comb begin
    cnt_next = cnt_reg + CW'(1);
    phase_next = phase_reg;
    if (cnt_reg == CNT_LAST) begin
      cnt_next = CNT_ZERO;
      phase_next = ~phase_reg;
    end
  end

  // Registers only
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_reg <= CNT_ZERO;
      phase_reg <= BCS_PHASE_RST;
    end else begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  // Rise marks the last low cycle before the phase goes high
  assign phase_next_out = phase_next;
  assign rise_out = (cnt_reg == CNT_LAST) && !phase_reg;

endmodule : bcs_divider

// ---- verilog/bcs_stop_ctrl.sv ----
// Stop gating for the stoppable bus clock outputs.
// Assumes halt pin and stop bit are synchronous to sys_clk_in; the
// management interface that holds the stop and free-run bits is outside.
`timescale 1ns/1ps
module bcs_stop_ctrl import bcs_pkg::*; #(
  parameter int NUM_STOP = BCS_NUM_STOP,
  parameter int NUM_FREE = BCS_NUM_FREE,
  parameter int HALF_CYC = BCS_HALF_PERIOD_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Stop controls
  input wire logic bus_clock_halt_n_in,
  input wire logic stop_bit_in,
  input wire logic [NUM_FREE-1:0] free_sel_in,
  // Clock outputs
  output logic [NUM_STOP-1:0] stop_clk_out,
  output logic [NUM_FREE-1:0] free_runnable_bus_clock_out,
  output logic ref_bus_clk_out,
  // Status
  output logic run_readback_out
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (NUM_STOP < 1 || NUM_FREE < 1) begin : g_bad_count
    $error("NUM_STOP and NUM_FREE must be at least one");
  end

  // Cycles allowed from run returning to outputs high again
  localparam int RESTART_CYC = BCS_RESTART_PERIODS * 2 * HALF_CYC;
  // Assertion helper width; saturates one above the restart limit
  localparam int CHK_W = $clog2(RESTART_CYC + 2);
  localparam logic [CHK_W-1:0] CHK_MAX = CHK_W'(RESTART_CYC + 1);
  localparam logic [CHK_W-1:0] CHK_LIMIT = CHK_W'(RESTART_CYC);

  logic phase_next;
  logic rise;
  logic run;
  bcs_state_t state_reg;
  bcs_state_t state_next;
  logic [NUM_STOP-1:0] stop_clk_reg;
  logic [NUM_STOP-1:0] stop_clk_next;
  logic [NUM_FREE-1:0] free_clk_reg;
  logic [NUM_FREE-1:0] free_clk_next;
  logic ref_clk_reg;
  logic ref_clk_next;
  logic readback_reg;
  logic readback_next;
  logic [NUM_FREE-1:0] free_mask_reg;
  logic [NUM_FREE-1:0] free_mask_next;
  logic [CHK_W-1:0] wait_cnt_reg;
  logic [CHK_W-1:0] wait_cnt_next;

  // True for the state in which stoppable outputs follow the phase
  function automatic logic is_running(input bcs_state_t st);
    return st == BCS_ST_RUNNING;
  endfunction : is_running

  // ************************************************************
  // Bus clock phase source
  // ************************************************************
  bcs_divider #(
    .HALF_CYC(HALF_CYC)
  ) u_divider (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .phase_next_out(phase_next),
    .rise_out(rise)
  );

  // Effective run condition
  assign run = bus_clock_halt_n_in & stop_bit_in;

  // ************************************************************
  // Gating state and outputs
  // ************************************************************
  // State is only resampled on the cycle before a rising edge, while
  // every clock output is low, so a stop or start never cuts a pulse short
  always_comb begin
    state_next = state_reg;
    if (rise) begin
      case (state_reg)
        BCS_ST_RUNNING: begin
          if (!run) begin
            state_next = BCS_ST_STOPPED;
          end
        end
        BCS_ST_STOPPED: begin
          if (run) begin
            state_next = BCS_ST_RUNNING;
          end
        end
        default: begin
          state_next = BCS_ST_STOPPED;
        end
      endcase
    end
    ref_clk_next = phase_next;
    stop_clk_next = {NUM_STOP{phase_next && is_running(state_next)}};
    // Free selects are taken only at a rise event, so flipping one while
    // the phase is high cannot cut or add a partial pulse
    free_mask_next = rise ? free_sel_in : free_mask_reg;
    // A free-running select keeps its output on the plain phase
    free_clk_next = {NUM_FREE{phase_next}} &
      (free_mask_next | {NUM_FREE{is_running(state_next)}});
    readback_next = run;
  end

  // Registers only
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= BCS_ST_STOPPED;
      stop_clk_reg <= '0;
      free_clk_reg <= '0;
      ref_clk_reg <= BCS_PHASE_RST;
      readback_reg <= BCS_READBACK_RST;
      free_mask_reg <= '0;
    end else begin
      state_reg <= state_next;
      stop_clk_reg <= stop_clk_next;
      free_clk_reg <= free_clk_next;
      ref_clk_reg <= ref_clk_next;
      readback_reg <= readback_next;
      free_mask_reg <= free_mask_next;
    end
  end

  assign stop_clk_out = stop_clk_reg;
  assign free_runnable_bus_clock_out = free_clk_reg;
  assign ref_bus_clk_out = ref_clk_reg;
  assign run_readback_out = readback_reg;

  // ************************************************************
  // Assertion helper
  // ************************************************************
  // Counts cycles spent stopped while run is high; saturates so that a
  // hung restart keeps the count above the limit instead of wrapping
  always_comb begin
    wait_cnt_next = '0;
    if (state_reg == BCS_ST_STOPPED && run) begin
      wait_cnt_next = wait_cnt_reg;
      if (wait_cnt_reg != CHK_MAX) begin
        wait_cnt_next = wait_cnt_reg + CHK_W'(1);
      end
    end
  end

  // Registers only
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_cnt_reg <= '0;
    end else begin
      wait_cnt_reg <= wait_cnt_next;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_halt_stops_outputs: assert property (
    (rise && !run) |=> (stop_clk_out == '0) && ref_bus_clk_out)
    else $error("stoppable clocks rose while halted");

  a_free_keeps_running: assert property (
    rise |=> ((free_runnable_bus_clock_out & $past(free_sel_in))
              == $past(free_sel_in)))
    else $error("free-running output failed to rise");

  a_restart_bound: assert property (
    $rose(run) |-> ##[1:RESTART_CYC]
      ((stop_clk_out == {NUM_STOP{1'b1}}) || !run))
    else $error("stopped clocks did not restart in time");

  a_stopped_held_low: assert property (
    (state_reg == BCS_ST_STOPPED) |-> (stop_clk_out == '0))
    else $error("stopped clocks not held low");

  a_readback_shows_stop: assert property (
    (!bus_clock_halt_n_in || !stop_bit_in) |=> !run_readback_out)
    else $error("read-back shows running while stopped");

  a_rise_aligned: assert property (
    $rose(stop_clk_out[0]) |-> $rose(ref_bus_clk_out))
    else $error("stoppable clock rose off the bus edge");

  a_fall_aligned: assert property (
    $fell(stop_clk_out[0]) |-> $fell(ref_bus_clk_out))
    else $error("stoppable clock fell off the bus edge");

  a_readback_running: assert property (
    (bus_clock_halt_n_in && stop_bit_in) |=> run_readback_out)
    else $error("read-back shows stopped while running");

  a_restart_count: assert property (
    wait_cnt_reg <= CHK_LIMIT)
    else $error("stopped clocks waited too long to restart");

  a_ref_keeps_running: assert property (
    rise |=> ref_bus_clk_out)
    else $error("ungated bus clock missed a rising edge");

  a_unselected_free_low: assert property (
    (state_reg == BCS_ST_STOPPED) |->
      ((free_runnable_bus_clock_out & ~free_mask_reg) == '0))
    else $error("unselected free clock ran while stopped");

  c_stop: cover property ($fell(state_reg == BCS_ST_RUNNING));
  c_restart: cover property ($rose(state_reg == BCS_ST_RUNNING));
  c_free_while_halted: cover property (
    (state_reg == BCS_ST_STOPPED) && free_runnable_bus_clock_out[0]);
  c_stop_by_bit: cover property (
    rise && bus_clock_halt_n_in && !stop_bit_in);
  c_free_select_taken: cover property (
    rise && (free_sel_in != free_mask_reg));

endmodule : bcs_stop_ctrl

// ---- tb/bcs_chipset_model.sv ----
// Model of the chipset that drives the bus clock halt pin.
// Assumes the bench changes stop_req_in at falling edges.
`timescale 1ns/1ps
module bcs_chipset_model #(
  parameter int LAG = 2
) (
  // Clock and request
  input wire logic sys_clk_in,
  input wire logic stop_req_in,
  // Halt pin, active low
  output logic bus_clock_halt_n_out
);
  logic [7:0] pipe_reg = 8'hFF;
  logic req_seen = 1'b0;
  // Request taken at the rising edge, where the bench holds it steady
  always @(posedge sys_clk_in) begin
    req_seen <= stop_req_in;
  end
  // Pin follows the request LAG cycles late, moved off the sampling edge
  always @(negedge sys_clk_in) begin
    pipe_reg <= {pipe_reg[6:0], ~req_seen};
  end
  assign bus_clock_halt_n_out = pipe_reg[LAG-1];
endmodule : bcs_chipset_model

// ---- tb/testbench.sv ----
// Self-checking bench for the bus clock stop control.
// Assumes HALF_CYC=1, so the bus clock toggles every system cycle.
`timescale 1ns/1ps
module testbench import bcs_pkg::*;;
  logic sys_clk;
  logic reset_n;
  logic stop_req;
  logic stop_bit;
  logic [2:0] free_sel;
  logic halt_n;
  logic [6:0] stop_clk;
  logic [2:0] free_clk;
  logic ref_clk;
  logic readback;
  int miscompares = 0;
  int samples_checked = 0;
  // Restart limit in system cycles: two bus periods
  localparam int RESTART_LIMIT = BCS_RESTART_PERIODS * 2 * BCS_HALF_PERIOD_CYC;

  bcs_chipset_model #(.LAG(2)) chipset (.sys_clk_in(sys_clk),
    .stop_req_in(stop_req), .bus_clock_halt_n_out(halt_n));
  bcs_stop_ctrl dut (.sys_clk_in(sys_clk), .reset_n_in(reset_n),
    .bus_clock_halt_n_in(halt_n), .stop_bit_in(stop_bit),
    .free_sel_in(free_sel), .stop_clk_out(stop_clk),
    .free_runnable_bus_clock_out(free_clk), .ref_bus_clk_out(ref_clk),
    .run_readback_out(readback));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cycles
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  // Counts cycles from run becoming true until the clocks toggle again
  task automatic restart_check;
    int n;
    n = 0;
    while (stop_clk === 7'h00 && n < 20) begin
      cycles(1);
      n++;
    end
    check(16'(n <= RESTART_LIMIT), 16'h1);
    check(16'(readback), 16'h1);
    check(16'({ref_clk, stop_clk}), 16'hFF);
    cycles(1);
    check(16'({ref_clk, stop_clk}), 16'h00);
  endtask : restart_check
  // Stoppable clocks may only be high with the reference; one high while it is low means a sliver
  always @(negedge sys_clk) begin
    if (reset_n) begin
      check(16'(stop_clk & ~{7{ref_clk}}), 16'h0);
    end
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_halt;
    logic prev;
    stop_req = 1'b1;
    cycles(7);
    repeat (4) begin
      prev = ref_clk;
      cycles(1);
      check(16'(ref_clk), 16'(!prev));
      check(16'(stop_clk), 16'h0);
      check(16'(free_clk), 16'h0);
      check(16'(readback), 16'h0);
    end
    $display("test_halt done");
  endtask : test_halt
  task automatic test_free;
    free_sel = 3'h5;
    cycles(2);
    repeat (4) begin
      cycles(1);
      check(16'(free_clk), 16'({ref_clk, 1'b0, ref_clk}));
    end
    free_sel = 3'h0;
    $display("test_free done");
  endtask : test_free
  task automatic test_restart;
    stop_req = 1'b0;
    wait (halt_n === 1'b1);
    restart_check();
    $display("test_restart done");
  endtask : test_restart
  // Second round starts one cycle later, so the stop bit falls and rises
  // once in each bus clock phase
  task automatic test_stop_bit;
    for (int k = 0; k < 2; k++) begin
      cycles(k);
      stop_bit = 1'b0;
      cycles(5);
      check(16'(stop_clk), 16'h0);
      check(16'(readback), 16'h0);
      stop_bit = 1'b1;
      restart_check();
    end
    $display("test_stop_bit done");
  endtask : test_stop_bit

  // Free-running clock, 25 ns period
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Main sequence; reset held for ten cycles
  initial begin
    reset_n = 1'b0;
    stop_req = 1'b0;
    stop_bit = 1'b1;
    free_sel = 3'h0;
    cycles(10);
    reset_n = 1'b1;
    cycles(4);
    test_halt();
    test_free();
    test_restart();
    test_stop_bit();
    end_of_test();
  end
  // Watchdog well past the few dozen cycles the tests need
  initial begin
    #50000;
    miscompares++;
    end_of_test();
  end
endmodule : testbench
